/* File: msc_pkg.sv */
// Constants and carrier types for the mode and system control block
package msc_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [15:0] REG_IDX_STATE = 16'hFFF0;
  localparam logic [15:0] REG_IDX_MODE = 16'hFFF1;
  localparam logic [15:0] REG_IDX_SYSCTL = 16'hFFF2;
  localparam logic [7:0] MODE_FIXED_BITS = 8'hC4;
  localparam logic [7:0] SYSCTL_RESET = 8'h0B;
  localparam logic [7:0] SYSCTL_RSVD_ONES = 8'h02;
  localparam int SC_STANDBY_BIT = 7;
  localparam int SC_SETTLE_LSB = 4;
  localparam int SC_USER_BIT = 3;
  localparam int SC_NMI_EDGE_BIT = 2;
  localparam int SC_RAM_EN_BIT = 0;
  localparam logic [1:0] REG_ACCESS_STATES = 2'h3;
  localparam logic [1:0] MEM_ACCESS_STATES = 2'h2;
  localparam logic [1:0] SLOW_ACCESS_STATES = 2'h3;
  localparam logic [1:0] BUS_WAIT_LAST = 2'h1;
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_TRAP_BASE = 6'h08;
  localparam logic [2:0] SETTLE_MAX_SHIFT = 3'h4;
  localparam int SETTLE_BASE_STATES = 8192;

  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_EXPAND_1M = 2'h1,
    MODE_SINGLE_64K = 2'h2,
    MODE_SINGLE_1M = 2'h3
  } msc_mode_t;

  typedef struct packed {
    logic [19:0] addr;
    logic rd;
    logic wr;
    logic word;
  } msc_cpu_acc_t;

  typedef struct packed {
    logic valid;
    logic wide_space;
    logic ext_allowed;
    logic init_bus8;
  } msc_mode_info_t;

  typedef struct packed {
    logic rom_sel;
    logic ram_sel;
    logic reg_sel;
    logic ext_sel;
    logic read_ones;
    logic drop_write;
    logic bus16;
    logic [2:0] area;
    logic [1:0] states;
  } msc_acc_dec_t;
endpackage

/* File: msc_top.sv */
// Mode straps, system control register, power states and exception entry
//
// Summary of operation
// - Every access is counted in clock states and lasts two or three.
// - On-chip memory takes two states over a 16-bit byte/word path.
// - Peripheral registers take three states, 8 or 16 bits wide.
// - External space has eight areas, each with own width and state count.
// - Strap pattern picks mode 1, 2 or 3; pattern 00 is unused.
// - Modes 2 and 3 with RAM disabled: RAM reads all ones, writes dropped.
// - Mode 1 with RAM disabled sends the RAM range to external memory.
// - Mode status reads 1 in bits 7, 6, 2 and 0 in bits 5..3.
// - Mode status low bits mirror the straps, sampled when read.
// - Standby select 0 makes sleep enter sleep mode, 1 software standby.
// - Standby select stays 1 after interrupt exit until software clears it.
// - Settle code picks 8192 to 131072 states after standby exit.
// - User flag enable 0 makes spare flag a mask, 1 a user flag.
// - NMI edge select 0 requests on falling edge, 1 on rising edge.
// - RAM enable resets to 1 on reset and survives software standby.
// - Mode 1: port 3 is the data bus, address pins follow direction bits.
// - Modes 2 and 3 never start an external bus access.
// - Reset beats interrupts beats traps; reset handling follows reset rise.
// - Interrupts wait for instruction or sequence end; traps always taken.
// - Traps and interrupts push PC and flags, mask, vector; reset skips push.
// - Reset vector is four bytes in 1-Mbyte modes, two in 64-kbyte mode.
`timescale 1ns/1ps
module msc_top #(
  parameter int SETTLE_BASE = msc_pkg::SETTLE_BASE_STATES,
  parameter logic [19:0] ROM_LAST = 20'h07FFF,
  parameter logic [19:0] RAM_BASE = 20'hFF710,
  parameter logic [19:0] RAM_LAST = 20'hFFF0F,
  parameter logic [19:0] REG_BASE = 20'hFFF10
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic [17:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic MODE_STRAP_HIGH_I,
  input wire logic MODE_STRAP_LOW_I,
  input wire logic NMI_PIN_I,
  input wire logic EXT_WAKE_PIN_I,
  input wire logic SLEEP_EXEC_I,
  input wire logic INSN_END_I,
  input wire logic IRQ_PEND_I,
  input wire logic [5:0] IRQ_VEC_I,
  input wire logic TRAP_EXEC_I,
  input wire logic [1:0] TRAP_NUM_I,
  input wire msc_pkg::msc_cpu_acc_t CPU_ACC_I,
  input wire logic [7:0] AREA_BUS16_I,
  input wire logic [7:0] AREA_SLOW_I,
  input wire logic [19:0] PORT_DIR_I,
  output msc_pkg::msc_mode_info_t MODE_INFO_O,
  output msc_pkg::msc_acc_dec_t ACC_DEC_O,
  output logic [19:0] ADDR_PIN_EN_O,
  output logic DATA_PORT_BUS_O,
  output logic NMI_REQ_O,
  output logic UI_IS_MASK_O,
  output logic SET_IMASK_O,
  output logic SET_UMASK_O,
  output logic [5:0] EXC_STEP_O,
  output logic [7:0] EXC_VEC_ADDR_O,
  output logic [3:0] POWER_STATE_O,
  output logic PERIPH_RESET_O
);
  import msc_pkg::*;

  typedef enum logic [3:0] {
    PW_RUN = 4'h1,
    PW_SLEEP = 4'h2,
    PW_STANDBY = 4'h4,
    PW_SETTLE = 4'h8
  } msc_pw_t;

  typedef enum logic [5:0] {
    EX_IDLE = 6'h01,
    EX_PUSH_PC = 6'h02,
    EX_PUSH_FLAGS = 6'h04,
    EX_MASK = 6'h08,
    EX_VECTOR = 6'h10,
    EX_BRANCH = 6'h20
  } msc_ex_t;

  // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  logic [2:0] strap_hi_sync;
  logic [2:0] strap_lo_sync;
  logic [2:0] nmi_sync;
  logic [2:0] wake_sync;
  logic strap_hi;
  logic strap_lo;
  logic nmi_level;
  logic wake_level;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      strap_hi_sync <= 3'h0;
      strap_lo_sync <= 3'h0;
      nmi_sync <= 3'h7;
      wake_sync <= 3'h0;
    end else begin
      strap_hi_sync <= {strap_hi_sync[1:0], MODE_STRAP_HIGH_I};
      strap_lo_sync <= {strap_lo_sync[1:0], MODE_STRAP_LOW_I};
      nmi_sync <= {nmi_sync[1:0], NMI_PIN_I};
      wake_sync <= {wake_sync[1:0], EXT_WAKE_PIN_I};
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      strap_hi <= 1'b0;
      strap_lo <= 1'b0;
      nmi_level <= 1'b1;
      wake_level <= 1'b0;
    end else begin
      if (strap_hi_sync[1] == strap_hi_sync[2]) begin
        strap_hi <= strap_hi_sync[2];
      end
      if (strap_lo_sync[1] == strap_lo_sync[2]) begin
        strap_lo <= strap_lo_sync[2];
      end
      if (nmi_sync[1] == nmi_sync[2]) begin
        nmi_level <= nmi_sync[2];
      end
      if (wake_sync[1] == wake_sync[2]) begin
        wake_level <= wake_sync[2];
      end
    end
  end

  // Mode decode; straps are trusted to stay fixed while running
  msc_mode_t mode;
  logic [7:0] sysctl;
  assign mode = msc_mode_t'({strap_hi, strap_lo});

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      MODE_INFO_O <= '0;
      DATA_PORT_BUS_O <= 1'b0;
      ADDR_PIN_EN_O <= 20'h00000;
      UI_IS_MASK_O <= 1'b0;
    end else begin
      MODE_INFO_O.valid <= (mode != MODE_NONE);
      MODE_INFO_O.wide_space <= (mode != MODE_SINGLE_64K);
      MODE_INFO_O.ext_allowed <= (mode == MODE_EXPAND_1M);
      MODE_INFO_O.init_bus8 <= (mode == MODE_EXPAND_1M);
      DATA_PORT_BUS_O <= (mode == MODE_EXPAND_1M);
      ADDR_PIN_EN_O <= (mode == MODE_EXPAND_1M) ? PORT_DIR_I : 20'h00000;
      UI_IS_MASK_O <= ~sysctl[SC_USER_BIT];
    end
  end

  // System control register; not touched by standby, only by the reset pin
  logic [31:0] wdata;
  logic bus_commit;
  logic reg_sysctl_hit;
  logic sleep_to_standby;

  assign wdata = AVS_WRITEDATA_I;
  assign reg_sysctl_hit = (AVS_ADDRESS_I[17:2] == REG_IDX_SYSCTL);

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sysctl <= SYSCTL_RESET;
    end else if (bus_commit && AVS_WRITE_I && reg_sysctl_hit &&
                 AVS_BYTEENABLE_I[0]) begin
      sysctl <= wdata[7:0] | SYSCTL_RSVD_ONES;
    end
  end

  assign sleep_to_standby = sysctl[SC_STANDBY_BIT];

  // Avalon slave: every register access spans three states
  logic [1:0] wait_cnt;
  logic settle_busy;
  logic bus_req;
  logic [7:0] rd_byte;

  assign bus_req = AVS_READ_I | AVS_WRITE_I;
  assign bus_commit = bus_req && !AVS_WAITREQUEST_O;

  always_comb begin
    rd_byte = 8'h00;
    case (AVS_ADDRESS_I[17:2])
      REG_IDX_MODE: rd_byte = MODE_FIXED_BITS |
                              {6'h00, strap_hi_sync[2],
                               strap_lo_sync[2]};
      REG_IDX_SYSCTL: rd_byte = sysctl;
      REG_IDX_STATE: rd_byte = {3'h0, settle_busy, POWER_STATE_O};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wait_cnt <= 2'h0;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h00000000;
    end else if (bus_commit) begin
      wait_cnt <= 2'h0;
      AVS_WAITREQUEST_O <= 1'b1;
    end else if (bus_req) begin
      if (wait_cnt == BUS_WAIT_LAST) begin
        AVS_WAITREQUEST_O <= 1'b0;
        // Straps are caught here, in the state before the one the read completes in
        AVS_READDATA_O <= {24'h000000, rd_byte};
      end
      wait_cnt <= wait_cnt + 2'h1;
    end
  end

  // NMI edge detect on the filtered pin level
  logic nmi_prev;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      nmi_prev <= 1'b1;
      NMI_REQ_O <= 1'b0;
    end else begin
      nmi_prev <= nmi_level;
      NMI_REQ_O <= sysctl[SC_NMI_EDGE_BIT] ? (nmi_level & ~nmi_prev)
                                          : (~nmi_level & nmi_prev);
    end
  end

  // CPU address decode, registered one state ahead of the data phase
  logic [19:0] eff_addr;
  logic in_rom;
  logic in_ram;
  logic in_reg;
  logic ram_on;
  logic single_chip;

  // The 64-kbyte space folds its upper half onto the top of the 1-Mbyte map
  assign eff_addr = (mode == MODE_SINGLE_64K) ?
                    {{4{CPU_ACC_I.addr[15]}}, CPU_ACC_I.addr[15:0]} :
                    CPU_ACC_I.addr;
  assign in_rom = (eff_addr <= ROM_LAST);
  assign in_ram = (eff_addr >= RAM_BASE) && (eff_addr <= RAM_LAST);
  assign in_reg = (eff_addr >= REG_BASE);
  assign ram_on = sysctl[SC_RAM_EN_BIT];
  assign single_chip = (mode != MODE_EXPAND_1M);

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ACC_DEC_O <= '0;
    end else begin
      ACC_DEC_O <= '0;
      ACC_DEC_O.area <= eff_addr[19:17];
      if (CPU_ACC_I.rd || CPU_ACC_I.wr) begin
        if (in_reg) begin
          ACC_DEC_O.reg_sel <= 1'b1;
          ACC_DEC_O.states <= REG_ACCESS_STATES;
          ACC_DEC_O.bus16 <= CPU_ACC_I.word;
        end else if (in_ram && (ram_on || single_chip)) begin
          ACC_DEC_O.ram_sel <= ram_on;
          ACC_DEC_O.read_ones <= ~ram_on & CPU_ACC_I.rd;
          ACC_DEC_O.drop_write <= ~ram_on & CPU_ACC_I.wr;
          ACC_DEC_O.states <= MEM_ACCESS_STATES;
          ACC_DEC_O.bus16 <= 1'b1;
        end else if (single_chip) begin
          // Outside ROM this is an unmapped access; no bus cycle starts
          ACC_DEC_O.rom_sel <= in_rom;
          ACC_DEC_O.states <= MEM_ACCESS_STATES;
          ACC_DEC_O.bus16 <= 1'b1;
        end else begin
          // Disabled RAM in mode 1 falls through to external memory
          ACC_DEC_O.ext_sel <= 1'b1;
          ACC_DEC_O.bus16 <= AREA_BUS16_I[eff_addr[19:17]];
          ACC_DEC_O.states <= AREA_SLOW_I[eff_addr[19:17]] ?
                              SLOW_ACCESS_STATES :
                              MEM_ACCESS_STATES;
        end
      end
    end
  end

  // Power states and oscillator settle counter
  msc_pw_t pw_state;
  logic [17:0] settle_cnt;
  logic [2:0] settle_shift;
  logic [17:0] settle_len;

  assign settle_busy = (pw_state == PW_SETTLE);
  // Code 11x is illegal; it is held to the longest wait rather than wrapping
  assign settle_shift = sysctl[SC_SETTLE_LSB + 2] ? SETTLE_MAX_SHIFT :
                        {1'b0, sysctl[SC_SETTLE_LSB +: 2]};
  assign settle_len = 18'(SETTLE_BASE) << settle_shift;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pw_state <= PW_RUN;
      settle_cnt <= 18'h00000;
    end else begin
      case (pw_state)
        PW_RUN: begin
          if (SLEEP_EXEC_I) begin
            pw_state <= sleep_to_standby ? PW_STANDBY : PW_SLEEP;
          end
        end
        PW_SLEEP: begin
          if (IRQ_PEND_I || NMI_REQ_O) begin
            pw_state <= PW_RUN;
          end
        end
        PW_STANDBY: begin
          if (wake_level || NMI_REQ_O) begin
            pw_state <= PW_SETTLE;
            settle_cnt <= settle_len - 18'h00001;
          end
        end
        PW_SETTLE: begin
          if (settle_cnt == 18'h00000) begin
            pw_state <= PW_RUN;
          end else begin
            settle_cnt <= settle_cnt - 18'h00001;
          end
        end
        default: pw_state <= PW_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      POWER_STATE_O <= PW_RUN;
      PERIPH_RESET_O <= 1'b0;
    end else begin
      POWER_STATE_O <= pw_state;
      PERIPH_RESET_O <= (pw_state == PW_STANDBY);
    end
  end

  // Exception entry sequencer
  msc_ex_t ex_state;
  logic reset_pend;
  logic trap_pend;
  logic [1:0] trap_num;
  logic irq_block;
  logic ex_is_reset;
  logic [5:0] ex_vec;
  logic irq_ok;
  logic seq_end;

  assign seq_end = (ex_state == EX_BRANCH);
  // Interrupts stay off after reset handling until one instruction has run
  assign irq_ok = IRQ_PEND_I && !irq_block && (pw_state == PW_RUN) &&
                  (INSN_END_I || seq_end);

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      trap_pend <= 1'b0;
      trap_num <= 2'h0;
    end else if (TRAP_EXEC_I && pw_state == PW_RUN) begin
      trap_pend <= 1'b1;
      trap_num <= TRAP_NUM_I;
    end else if (ex_state == EX_IDLE && !reset_pend && !irq_ok) begin
      trap_pend <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      reset_pend <= 1'b1;
      irq_block <= 1'b1;
      ex_state <= EX_IDLE;
      ex_is_reset <= 1'b0;
      ex_vec <= VEC_RESET;
    end else begin
      if (INSN_END_I && ex_state == EX_IDLE && !reset_pend) begin
        irq_block <= 1'b0;
      end
      case (ex_state)
        EX_IDLE: begin
          if (reset_pend) begin
            reset_pend <= 1'b0;
            ex_is_reset <= 1'b1;
            ex_vec <= VEC_RESET;
            ex_state <= EX_MASK;
          end else if (irq_ok) begin
            ex_is_reset <= 1'b0;
            ex_vec <= IRQ_VEC_I;
            ex_state <= EX_PUSH_PC;
          end else if (trap_pend) begin
            ex_is_reset <= 1'b0;
            ex_vec <= VEC_TRAP_BASE + {4'h0, trap_num};
            ex_state <= EX_PUSH_PC;
          end
        end
        EX_PUSH_PC: ex_state <= EX_PUSH_FLAGS;
        EX_PUSH_FLAGS: ex_state <= EX_MASK;
        EX_MASK: ex_state <= EX_VECTOR;
        EX_VECTOR: ex_state <= EX_BRANCH;
        EX_BRANCH: begin
          if (irq_ok && !ex_is_reset) begin
            ex_vec <= IRQ_VEC_I;
            ex_state <= EX_PUSH_PC;
          end else begin
            ex_state <= EX_IDLE;
          end
        end
        default: ex_state <= EX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      EXC_STEP_O <= EX_IDLE;
      EXC_VEC_ADDR_O <= 8'h00;
      SET_IMASK_O <= 1'b0;
      SET_UMASK_O <= 1'b0;
    end else begin
      EXC_STEP_O <= ex_state;
      EXC_VEC_ADDR_O <= (mode == MODE_SINGLE_64K) ? {1'b0, ex_vec, 1'b0}
                                                  : {ex_vec, 2'h0};
      SET_IMASK_O <= (ex_state == EX_MASK);
      SET_UMASK_O <= (ex_state == EX_MASK) && !ex_is_reset &&
                     !sysctl[SC_USER_BIT];
    end
  end
endmodule // msc_top

/* File: msc_strap_model.sv */
// Board strap model: holds one mode pattern steady while the chip runs
`timescale 1ns/1ps
module msc_strap_model (
  input wire logic rst_n_i,
  input wire logic [1:0] pick_i,
  output logic high_o,
  output logic low_o
);
  // Pattern may only move while reset holds the chip, never in operation
  always_latch begin
    if (!rst_n_i) begin
      {high_o, low_o} <= pick_i;
    end
  end
endmodule // msc_strap_model

/* File: msc_checker.sv */
// Port assertions for the mode and system control block
`timescale 1ns/1ps
module msc_checker #(
  parameter logic [19:0] REG_BASE = 20'hFFF10
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic [17:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic MODE_STRAP_HIGH_I,
  input wire logic MODE_STRAP_LOW_I,
  input wire msc_pkg::msc_cpu_acc_t CPU_ACC_I,
  input wire logic [19:0] PORT_DIR_I,
  input wire msc_pkg::msc_mode_info_t MODE_INFO_O,
  input wire msc_pkg::msc_acc_dec_t ACC_DEC_O,
  input wire logic [19:0] ADDR_PIN_EN_O,
  input wire logic DATA_PORT_BUS_O,
  input wire logic UI_IS_MASK_O,
  input wire logic SET_IMASK_O,
  input wire logic SET_UMASK_O,
  input wire logic [5:0] EXC_STEP_O
);
  import msc_pkg::*;
  logic [1:0] straps;
  logic mode_rd;
  assign straps = {MODE_STRAP_HIGH_I, MODE_STRAP_LOW_I};
  assign mode_rd = AVS_READ_I && !AVS_WAITREQUEST_O
    && AVS_ADDRESS_I[17:2] == REG_IDX_MODE;
  default clocking @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);
  sequence s_done;
    !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endsequence
  sequence s_mask_tail;
    EXC_STEP_O == 6'h08 ##1 EXC_STEP_O == 6'h10 ##1 EXC_STEP_O == 6'h20;
  endsequence
  property p_reg_states;
    $rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O [*2] ##1 s_done;
  endproperty
  a_reg_states: assert property (p_reg_states) else $error("slow reg");
  property p_idle_wait;
    !(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("idle ack");
  property p_mode_fixed;
    mode_rd |-> AVS_READDATA_O[31:2] == {24'h0, MODE_FIXED_BITS[7:2]};
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("fixed");
  property p_mode_pins;
    mode_rd |-> AVS_READDATA_O[1:0] == straps;
  endproperty
  a_mode_pins: assert property (p_mode_pins) else $error("pins");
  property p_dec_reg;
    CPU_ACC_I.rd && CPU_ACC_I.addr >= REG_BASE |=>
      ACC_DEC_O.reg_sel && ACC_DEC_O.states == REG_ACCESS_STATES;
  endproperty
  a_dec_reg: assert property (p_dec_reg) else $error("reg dec");
  property p_dec_ram;
    ACC_DEC_O.ram_sel |-> ACC_DEC_O.bus16
      && ACC_DEC_O.states == MEM_ACCESS_STATES;
  endproperty
  a_dec_ram: assert property (p_dec_ram) else $error("ram dec");
  property p_single;
    MODE_STRAP_HIGH_I && MODE_INFO_O.valid |-> !ACC_DEC_O.ext_sel;
  endproperty
  a_single: assert property (p_single) else $error("ext access");
  property p_pins_m1;
    straps == 2'h1 && MODE_INFO_O.valid |=>
      DATA_PORT_BUS_O && ADDR_PIN_EN_O == $past(PORT_DIR_I);
  endproperty
  a_pins_m1: assert property (p_pins_m1) else $error("addr pins");
  property p_mode_info;
    MODE_INFO_O.valid |-> MODE_INFO_O.wide_space == MODE_STRAP_LOW_I
      && MODE_INFO_O.ext_allowed == (straps == 2'h1);
  endproperty
  a_mode_info: assert property (p_mode_info) else $error("mode");
  property p_exc_push;
    EXC_STEP_O == 6'h02 |=> EXC_STEP_O == 6'h04 ##1 s_mask_tail;
  endproperty
  a_exc_push: assert property (p_exc_push) else $error("exc order");
  // Reset entry skips the push steps, so only pushed entries are checked
  property p_mask_pulse;
    EXC_STEP_O == 6'h08 && $past(EXC_STEP_O) == 6'h04 |->
      SET_IMASK_O && SET_UMASK_O == UI_IS_MASK_O;
  endproperty
  a_mask_pulse: assert property (p_mask_pulse) else $error("mask");
endmodule // msc_checker
bind msc_top msc_checker #(.REG_BASE(REG_BASE)) u_check (
  .CLK_SYS_I, .RESET_N_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_READDATA_O, .AVS_WAITREQUEST_O, .MODE_STRAP_HIGH_I,
  .MODE_STRAP_LOW_I, .CPU_ACC_I, .PORT_DIR_I, .MODE_INFO_O, .ACC_DEC_O,
  .ADDR_PIN_EN_O, .DATA_PORT_BUS_O, .UI_IS_MASK_O, .SET_IMASK_O,
  .SET_UMASK_O, .EXC_STEP_O
);

/* File: mode_and_system_control_bench.sv */
// Self-checking bench for the mode and system control block
`timescale 1ns/1ps
module mode_and_system_control_bench;
  import msc_pkg::*;
  typedef struct packed {
    logic [15:0] idx;
    logic w;
    logic [7:0] d;
    logic [7:0] exp;
  } msc_row_t;
  localparam int SETTLE = 4;
  localparam msc_row_t ROWS [5] = '{'{REG_IDX_SYSCTL, 1'b1, 8'hFD, 8'hFF},
    '{REG_IDX_MODE, 1'b1, 8'h00, 8'hC5}, '{16'hFFF3, 1'b1, 8'h5A, 8'h00},
    '{REG_IDX_SYSCTL, 1'b1, 8'h0B, 8'h0B},
    '{REG_IDX_STATE, 1'b0, 8'h00, 8'h01}};
  localparam logic [2:0] CODES [4] = '{3'h0, 3'h3, 3'h4, 3'h6};
  localparam int SHIFTS [4] = '{0, 3, 4, 4};
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, nmi = 1'b1;
  logic wake = 1'b0, slp = 1'b0, iend = 1'b0, irq = 1'b0, trap = 1'b0;
  logic s_hi, s_lo, wreq, dport, nmi_req, ui_mask, imask, umask, prst;
  logic [1:0] pick = 2'h1, tnum = 2'h0;
  logic [17:0] adr = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [3:0] be = 4'hF, pwr;
  logic [19:0] pin_en;
  logic [5:0] step;
  logic [7:0] vaddr;
  msc_cpu_acc_t cpu = '0;
  msc_mode_info_t minfo;
  msc_acc_dec_t dec;
  int errors = 0, tests_run = 0, n;
  always #20 clk = ~clk;
  msc_strap_model i_straps (.rst_n_i(rst_n), .pick_i(pick),
    .high_o(s_hi), .low_o(s_lo));
  msc_top #(.SETTLE_BASE(SETTLE)) i_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .MODE_STRAP_HIGH_I(s_hi),
    .MODE_STRAP_LOW_I(s_lo), .NMI_PIN_I(nmi), .EXT_WAKE_PIN_I(wake),
    .SLEEP_EXEC_I(slp), .INSN_END_I(iend), .IRQ_PEND_I(irq),
    .IRQ_VEC_I(6'h0C), .TRAP_EXEC_I(trap), .TRAP_NUM_I(tnum),
    .CPU_ACC_I(cpu), .AREA_BUS16_I(8'h20), .AREA_SLOW_I(8'h20),
    .PORT_DIR_I(20'h0F0F3), .MODE_INFO_O(minfo), .ACC_DEC_O(dec),
    .ADDR_PIN_EN_O(pin_en), .DATA_PORT_BUS_O(dport), .NMI_REQ_O(nmi_req),
    .UI_IS_MASK_O(ui_mask), .SET_IMASK_O(imask), .SET_UMASK_O(umask),
    .EXC_STEP_O(step), .EXC_VEC_ADDR_O(vaddr), .POWER_STATE_O(pwr),
    .PERIPH_RESET_O(prst));
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Master holds the request until it samples waitrequest low
  task automatic av(input logic w, input logic [15:0] idx,
                    input logic [7:0] d, input logic [3:0] b);
    int k;
    @(posedge clk);
    adr <= {idx, 2'h0};
    rd <= !w;
    wr <= w;
    wdat <= {24'h0, d};
    be <= b;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 40);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 40) begin
      check("ack", 0, 1);
      end_sim();
    end
  endtask
  task automatic wait_on(input logic power, input logic [5:0] v);
    int k;
    k = 0;
    while ((power ? {2'h0, pwr} : step) !== v && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (k >= 300) begin
      check("wait", 0, v);
      end_sim();
    end
  endtask
  task automatic cpu_go(input logic [19:0] a, input logic w);
    @(posedge clk);
    cpu <= '{addr: a, rd: !w, wr: w, word: 1'b0};
    @(posedge clk);
    cpu <= '0;
    @(negedge clk);
  endtask
  task automatic do_reset(input logic [1:0] p);
    @(posedge clk);
    rst_n <= 1'b0;
    pick <= p;
    repeat (20) @(posedge clk);
    check("rst", {wreq, pwr, step}, {1'b1, 4'h1, 6'h01});
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic nmi_edge(input logic v, input int exp);
    int k;
    @(posedge clk);
    nmi <= v;
    k = 0;
    repeat (12) begin
      @(negedge clk);
      k += int'(nmi_req === 1'b1);
    end
    check("nmi", k, exp);
  endtask
  task automatic mode_case(input logic [1:0] m);
    logic [19:0] base;
    base = (m == 2'h2) ? 20'h0F000 : 20'hFF000;
    do_reset(m);
    av(1'b0, REG_IDX_SYSCTL, 8'h00, 4'hF);
    check("sysctl", q, SYSCTL_RESET);
    check("info", minfo, {1'b1, m != 2'h2, m == 2'h1, m == 2'h1});
    check("pins", {dport, pin_en}, {21{m == 2'h1}} & 21'h10F0F3);
    av(1'b0, REG_IDX_MODE, 8'h00, 4'hF);
    check("mode", q, {24'h0, 6'h31, m});
    cpu_go(base + 20'h710, 1'b0);
    check("ram", {dec[11:8], dec.states}, {4'h4, 2'h2});
    cpu_go(base + 20'hF20, 1'b0);
    check("reg", {dec[11:8], dec.states}, {4'h2, 2'h3});
    cpu_go(20'hA0000, 1'b0);
    if (m == 2'h1) begin
      check("ext", {dec[11:8], dec[5:0]}, {4'h1, 1'b1, 3'h5, 2'h3});
    end else begin
      check("ext", dec.ext_sel, 1'b0);
    end
    av(1'b1, REG_IDX_SYSCTL, 8'h02, 4'hF);
    // The flag output is registered one clock after the write lands
    repeat (2) @(negedge clk);
    check("uimask", ui_mask, 1'b1);
    cpu_go(base + 20'h710, 1'b0);
    if (m == 2'h1) begin
      check("ramoff", {dec.ram_sel, dec.ext_sel}, 2'h1);
    end else begin
      check("ramoff", {dec.ram_sel, dec.read_ones}, 2'h1);
      cpu_go(base + 20'h710, 1'b1);
      check("ramwr", {dec.ram_sel, dec.drop_write}, 2'h1);
    end
    @(posedge clk);
    tnum <= 2'h3;
    trap <= 1'b1;
    @(posedge clk);
    trap <= 1'b0;
    wait_on(1'b0, 6'h10);
    check("vec", vaddr, (m == 2'h2) ? 8'h16 : 8'h2C);
    wait_on(1'b0, 6'h01);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    check("timeout", 0, 1);
    end_sim();
  end
  initial begin
    do_reset(2'h1);
    av(1'b1, REG_IDX_SYSCTL, 8'h00, 4'hE);
    av(1'b0, REG_IDX_SYSCTL, 8'h00, 4'hF);
    check("lane", q, SYSCTL_RESET);
    foreach (ROWS[i]) begin
      if (ROWS[i].w) begin
        av(1'b1, ROWS[i].idx, ROWS[i].d, 4'hF);
      end
      av(1'b0, ROWS[i].idx, 8'h00, 4'hF);
      check("row", q, ROWS[i].exp);
    end
    // Ending the first instruction lifts the interrupt block left by reset
    @(posedge clk);
    slp <= 1'b1;
    iend <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    iend <= 1'b0;
    wait_on(1'b1, 6'h02);
    check("sleep", prst, 1'b0);
    @(posedge clk);
    irq <= 1'b1;
    wait_on(1'b1, 6'h01);
    repeat (3) @(posedge clk);
    check("noend", step, 6'h01);
    iend <= 1'b1;
    trap <= 1'b1;
    tnum <= 2'h0;
    @(posedge clk);
    iend <= 1'b0;
    trap <= 1'b0;
    wait_on(1'b0, 6'h02);
    @(posedge clk);
    irq <= 1'b0;
    wait_on(1'b0, 6'h10);
    check("irq", vaddr, 8'h30);
    wait_on(1'b0, 6'h01);
    wait_on(1'b0, 6'h10);
    check("trap", vaddr, 8'h20);
    // Settle lengths are shortened by the small SETTLE_BASE
    foreach (CODES[i]) begin
      av(1'b1, REG_IDX_SYSCTL, {1'b1, CODES[i], 4'hB}, 4'hF);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      wait_on(1'b1, 6'h04);
      check("stby", prst, 1'b1);
      @(posedge clk);
      wake <= 1'b1;
      wait_on(1'b1, 6'h08);
      n = 0;
      while (pwr === 4'h8 && n < 300) begin
        @(negedge clk);
        n++;
      end
      check("settle", n, SETTLE << SHIFTS[i]);
      @(posedge clk);
      wake <= 1'b0;
      av(1'b0, REG_IDX_SYSCTL, 8'h00, 4'hF);
      check("keep", q, {1'b1, CODES[i], 4'hB});
    end
    av(1'b1, REG_IDX_SYSCTL, 8'h0B, 4'hF);
    nmi_edge(1'b0, 1);
    nmi_edge(1'b1, 0);
    av(1'b1, REG_IDX_SYSCTL, 8'h0F, 4'hF);
    nmi_edge(1'b0, 0);
    nmi_edge(1'b1, 1);
    for (int m = 1; m < 4; m++) begin
      mode_case(m[1:0]);
    end
    end_sim();
  end
endmodule // mode_and_system_control_bench
